// File: hdl/ea_unit_pkg.sv
// Constants and types shared by the effective address unit
package ea_unit_pkg;
	typedef enum logic [1:0] {sect14_mode, sect15_mode, rel15_mode, rel16_mode} mode_t;
	typedef enum logic [1:0] {class_sectored, class_relative, class_extended} addr_class_t;
	// Instruction word fields, bit 1 of the word is bit 15 here
	localparam int IND_BIT = 15;
	localparam int IDX_BIT = 14;
	localparam int SECT_BIT = 9;
	localparam int DISP_MSB = 8;
	localparam int DISP_W = 9;
	localparam int PC_SECT_LSB = 9;
	localparam int SECT14_PC_MSB = 13;
	localparam int SECT15_PC_MSB = 14;
	// Displacement limits, two's complement 9 bits
	localparam logic [8:0] REL_MIN_DISP = 9'h110;
	localparam logic [8:0] PREINDEX_LIMIT = 9'h040;
	// Address widths per mode
	localparam int ADDR_W = 16;
	localparam int SECT14_BITS = 14;
	localparam int SECT15_BITS = 15;
	localparam int REL16_BITS = 16;
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [1:0] CLASS_RESET = 2'h0;
endpackage : ea_unit_pkg

// File: hdl/effective_address_unit.sv
// Effective address generator for memory reference instructions
//
// Overview of operation
// RULE1: Bit 1 indirect, bit 2 index, bit 7 sector, bits 8-16 displacement.
// RULE2: Index register load/store instructions use the index bit as opcode.
// RULE3: Class from mode, sector flag and displacement range.
// RULE4: Long reach and stack relative two words; stack push/pop one word.
// RULE5: Sectored memory is 512-word sectors addressed by 9-bit displacement.
// RULE6: Sector flag 0 puts displacement in sector zero.
// RULE7: Sector flag 1 in 14-bit mode concatenates program counter bits 3-7.
// RULE8: Indexing adds index register two's complement, truncated to the mode.
// RULE9: Indirection repeats until a word with indirect flag 0.
// RULE10: 16-bit relative indirect words are full addresses, one level only.
// RULE11: Final address truncated to 14, 15 or 16 bits by mode.
// RULE12: Program counter is not truncated; only formed addresses are.
// RULE13: Address beyond installed memory raises missing-memory trap.
// RULE14: Power-up and panel clear select the 14-bit sectored mode.
// RULE15: 14-bit mode indexes before and after indirection.
// RULE16: 14-bit mode pre-indexes the instruction, post-indexes flagged words.
// RULE17: 15-bit sectored post-indexes, pre-indexing only for S=0, D<'100.
// RULE18: Relative forms PC+1+D, then indirection, then indexing.
// RULE19: Two-word extended instructions never take relative addressing.
// RULE20: Sector and relative bases use the pre-fetch program counter.
// RULE21: Final address is presented with a one-cycle completion pulse.
// RULE22: Sequencer holds inputs stable; memory returns each indirect word.
`timescale 1ns/1ps
`default_nettype none
module effective_address_unit
	import ea_unit_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic panel_clear,
	input wire logic mode_write,
	input wire ea_unit_pkg::mode_t mode_new,
	input wire logic start,
	input wire logic [15:0] instr,
	input wire logic [15:0] pc,
	input wire logic [15:0] index_reg,
	input wire logic index_op,
	input wire logic [15:0] mem_top,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_valid,
	output logic mem_read,
	output logic [15:0] mem_addr,
	output logic [15:0] effective_address,
	output logic done,
	output logic busy,
	output logic extended,
	output logic two_word,
	output logic [1:0] ext_class,
	output logic missing_memory_trap,
	output ea_unit_pkg::mode_t mode
);
	import ea_unit_pkg::*;

	typedef enum logic [1:0] {st_idle, st_fetch, st_wait, st_finish} state_t;

	// Keep only the address bits that the mode makes significant
	function automatic logic [15:0] trunc(input logic [15:0] a, input mode_t m);
		logic [15:0] r;
		r = a;
		case (m)
			sect14_mode: r = {2'h0, a[SECT14_BITS-1:0]};
			sect15_mode: r = {1'h0, a[SECT15_BITS-1:0]};
			rel15_mode: r = {1'h0, a[SECT15_BITS-1:0]};
			default: r = a[REL16_BITS-1:0];
		endcase
		return r;
	endfunction : trunc

	// Both relative modes share the class split on the sector flag
	function automatic logic mode_is_relative(input mode_t m);
		return (m == rel15_mode) || (m == rel16_mode);
	endfunction : mode_is_relative

	// Displacements -256 to -241 carry an extended form, not an address
	function automatic logic in_ext_range(input logic [8:0] d);
		return d[8] && (d < REL_MIN_DISP);
	endfunction : in_ext_range

	// Sign-extend the displacement for relative forms
	function automatic logic [15:0] sext_disp(input logic [8:0] d);
		return {{7{d[8]}}, d};
	endfunction : sext_disp

	// Indirect flag of a returned word; full-width words carry none
	function automatic logic word_indirect(input logic [15:0] w, input mode_t m);
		logic f;
		f = 1'b0;
		case (m)
			sect14_mode: f = w[IND_BIT]; // RULE9
			sect15_mode: f = w[IND_BIT]; // RULE9
			rel15_mode: f = w[IND_BIT]; // RULE9
			default: f = 1'b0; // RULE10
		endcase
		return f;
	endfunction : word_indirect

	// Only the 14-bit sectored mode leaves room for an index flag in a word
	function automatic logic word_indexed(input logic [15:0] w, input mode_t m);
		logic f;
		f = 1'b0;
		if (m == sect14_mode) begin
			f = w[IDX_BIT]; // RULE15 RULE16
		end
		return f;
	endfunction : word_indexed

	// A request is taken only from idle and never under a panel clear
	function automatic logic request_taken(input state_t s, input logic go, input logic clr);
		return (s == st_idle) && go && !clr;
	endfunction : request_taken

	// Classify by mode, sector flag and signed displacement
	function automatic addr_class_t classify(input logic s, input logic [8:0] d, input mode_t m);
		addr_class_t c;
		c = class_sectored;
		if (mode_is_relative(m) && s) begin // RULE3
			if (in_ext_range(d)) begin // RULE19
				c = class_extended;
			end else begin
				c = class_relative;
			end
		end
		return c;
	endfunction : classify

	state_t state;
	logic [15:0] addr;
	logic post_index;

	logic ind_f;
	logic idx_f;
	logic sect_f;
	logic [8:0] disp;
	addr_class_t cls;
	logic [15:0] base;
	logic pre_index;
	logic [15:0] first_addr;
	logic word_ind;
	logic word_idx;
	logic [15:0] word_addr;
	logic [15:0] final_addr;
	logic take;

	assign ind_f = instr[IND_BIT]; // RULE1
	assign idx_f = instr[IDX_BIT] & ~index_op; // RULE2
	assign sect_f = instr[SECT_BIT]; // RULE1
	assign disp = instr[DISP_MSB:0]; // RULE1
	assign cls = classify(sect_f, disp, mode);
	assign take = request_taken(state, start, panel_clear);

	// Base address of the chain
	always_comb begin
		base = {7'h00, disp}; // RULE6
		if (cls == class_relative) begin
			base = pc + 16'h0001 + sext_disp(disp); // RULE18 RULE20
		end else if (sect_f) begin
			if (mode == sect14_mode) begin
				base = {2'h0, pc[SECT14_PC_MSB:PC_SECT_LSB], disp}; // RULE7 RULE20
			end else begin
				base = {1'h0, pc[SECT15_PC_MSB:PC_SECT_LSB], disp}; // RULE5 RULE20
			end
		end
	end

	// Pre-index unless the mode defers indexing past the indirect chain
	always_comb begin
		pre_index = 1'b0;
		if (idx_f) begin
			if (!ind_f) begin
				pre_index = 1'b1; // RULE18
			end else if (mode == sect14_mode) begin
				pre_index = 1'b1; // RULE15 RULE16
			end else if (cls == class_sectored && !sect_f && disp < PREINDEX_LIMIT) begin
				pre_index = 1'b1; // RULE17
			end
		end
	end

	assign first_addr = trunc(base + (pre_index ? index_reg : 16'h0000), mode); // RULE8

	// Interpret a returned indirect word according to the mode
	always_comb begin
		word_ind = word_indirect(mem_rdata, mode); // RULE9 RULE10
		word_idx = word_indexed(mem_rdata, mode); // RULE16
		word_addr = trunc(mem_rdata, mode); // RULE17
		if (word_idx) begin
			word_addr = word_addr + index_reg; // RULE15
		end
		word_addr = trunc(word_addr, mode); // RULE8
	end

	// Deferred index added once the chain ends
	assign final_addr = trunc(addr + (post_index ? index_reg : 16'h0000), mode); // RULE11 RULE17 RULE18

	// Mode register; program counter is never touched here, so it may run past the range
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode <= sect14_mode; // RULE14
		end else if (panel_clear) begin
			mode <= sect14_mode; // RULE14
		end else if (mode_write && state == st_idle) begin
			mode <= mode_new; // RULE12
		end
	end

	// Forming address: first step on a taken request, then each returned word
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addr <= ADDR_RESET;
		end else if (take) begin
			addr <= first_addr; // RULE8
		end else if (state == st_wait && mem_valid) begin
			addr <= word_addr; // RULE9
		end
	end

	// Index deferred past the indirect chain
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			post_index <= 1'b0;
		end else if (take) begin
			post_index <= idx_f & ~pre_index; // RULE17 RULE18
		end
	end

	// Address calculation sequence
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= st_idle;
		end else begin
			case (state)
				st_idle: begin
					if (take) begin
						if (cls == class_extended) begin
							state <= st_finish; // RULE4
						end else if (ind_f) begin
							state <= st_fetch; // RULE9
						end else begin
							state <= st_finish;
						end
					end
				end
				st_fetch: begin
					state <= st_wait;
				end
				st_wait: begin
					if (mem_valid) begin // RULE22
						state <= word_ind ? st_fetch : st_finish; // RULE9 RULE10
					end
				end
				st_finish: begin
					state <= st_idle;
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// Memory read request, one cycle per indirect level
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_read <= 1'b0;
		end else begin
			mem_read <= (state == st_fetch); // RULE9
		end
	end

	// Read address held until the next level so a slow memory sees it stable
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_addr <= ADDR_RESET;
		end else if (state == st_fetch) begin
			mem_addr <= addr;
		end
	end

	// Completion pulse to the sequencer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			done <= 1'b0;
		end else begin
			done <= (state == st_finish); // RULE21
		end
	end

	// Busy from the cycle after a taken request up to the done pulse
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
		end else begin
			busy <= (state != st_idle) || take;
		end
	end

	// Extended class report, captured when a request is taken
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			extended <= 1'b0;
			two_word <= 1'b0;
			ext_class <= CLASS_RESET;
		end else if (take) begin
			extended <= (cls == class_extended); // RULE3
			two_word <= (cls == class_extended) && !instr[1]; // RULE4
			ext_class <= (cls == class_extended) ? instr[1:0] : CLASS_RESET;
		end
	end

	// Extended forms are only classified here, so they report a zero address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			effective_address <= ADDR_RESET;
		end else if (state == st_finish) begin
			if (!extended) begin
				effective_address <= final_addr; // RULE11 RULE21
			end else begin
				effective_address <= ADDR_RESET;
			end
		end
	end

	// Trap pulse only when a formed address passes the installed memory
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			missing_memory_trap <= 1'b0;
		end else begin
			missing_memory_trap <= (state == st_finish) && !extended && (final_addr > mem_top); // RULE13
		end
	end
endmodule : effective_address_unit
`default_nettype wire

// File: verif/ea_checker.sv
// Port assertions for the effective address unit
`timescale 1ns/1ps
`default_nettype none
module ea_checker
	import ea_unit_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic panel_clear,
	input wire logic start,
	input wire logic [15:0] instr,
	input wire logic [15:0] pc,
	input wire logic [15:0] mem_top,
	input wire logic mem_read,
	input wire logic [15:0] effective_address,
	input wire logic done,
	input wire logic busy,
	input wire logic missing_memory_trap,
	input wire ea_unit_pkg::mode_t mode
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Only direct requests, since indirect ones wait on memory
	sequence s_go; start && !busy && !done && !panel_clear && !instr[15]; endsequence
	sequence s_finish; ##1 busy ##1 done; endsequence
	property p_time; s_go |-> s_finish; endproperty
	a_time: assert property (p_time) else $error("direct request late");
	property p_end; done |=> !done && !busy; endproperty
	a_end: assert property (p_end) else $error("done not a pulse");
	property p_sect0; s_go ##0 !instr[14] && !instr[9] |-> ##2 effective_address == {7'h0, instr[8:0]}; endproperty
	a_sect0: assert property (p_sect0) else $error("sector zero address");
	property p_sect14;
		s_go ##0 !instr[14] && instr[9] && mode == sect14_mode |-> ##2 effective_address == {2'h0, pc[13:9], instr[8:0]};
	endproperty
	a_sect14: assert property (p_sect14) else $error("current sector address");
	property p_trap; missing_memory_trap == (done && effective_address > mem_top); endproperty
	a_trap: assert property (p_trap) else $error("trap wrong");
	property p_clear; panel_clear |=> mode == sect14_mode; endproperty
	a_clear: assert property (p_clear) else $error("clear mode");
	property p_width; done && mode != rel16_mode |-> !effective_address[15] && (mode != sect14_mode || !effective_address[14]); endproperty
	a_width: assert property (p_width) else $error("address not truncated");
	property p_read; mem_read |-> busy ##1 !mem_read; endproperty
	a_read: assert property (p_read) else $error("memory read not a pulse");
endmodule : ea_checker
bind effective_address_unit ea_checker chk (.*);
`default_nettype wire

// File: verif/mem_model.sv
// Memory model returning indirect words to the unit
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input wire logic clock,
	input wire logic mem_read,
	input wire logic [15:0] mem_addr,
	input wire logic [3:0] lat,
	output logic [15:0] mem_rdata,
	output logic mem_valid
);
	logic [15:0] words [logic [15:0]];
	initial {mem_valid, mem_rdata} = 17'h0;
	// Stale data is inverted so a late sample cannot pass by luck
	always @(posedge clock) begin
		if (mem_read) begin
			repeat (lat) @(posedge clock);
			mem_rdata <= words.exists(mem_addr) ? words[mem_addr] : 16'h0;
			mem_valid <= 1'h1;
			@(posedge clock);
			mem_valid <= 1'h0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : mem_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the effective address unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb_top;
	import ea_unit_pkg::*;
	logic clock = 1'h0, rst = 1'h1, panel_clear = 1'h0, mode_write = 1'h0, start = 1'h0, index_op = 1'h0;
	logic mem_read, mem_valid, done, busy, extended, two_word, missing_memory_trap;
	logic [1:0] ext_class;
	logic [3:0] lat = 4'h0;
	logic [15:0] instr = 16'h0, pc = 16'h0, index_reg = 16'h0, mem_top = 16'hffff;
	logic [15:0] mem_rdata, mem_addr, effective_address;
	mode_t mode_new = sect14_mode, mode;
	int fail_count = 0, comparisons = 0;
	always #2 clock = ~clock;
	effective_address_unit uut (.*);
	mem_model mem_i (.*);
	// Inputs stay put until the next call, as the unit expects them stable
	task automatic calc(input mode_t m, input logic [15:0] w, p, x, e);
		int n;
		mode_new = m;
		mode_write = 1'h1;
		@(negedge clock);
		mode_write = 1'h0;
		{instr, pc, index_reg, start} = {w, p, x, 1'h1};
		@(negedge clock);
		start = 1'h0;
		for (n = 0; n < 40 && done !== 1'h1; n++) @(negedge clock);
		`CHK(done, 1'h1)
		`CHK(effective_address, e)
		`CHK(missing_memory_trap, e > mem_top)
		@(negedge clock);
	endtask : calc
	task automatic t_sect();
		calc(sect14_mode, 16'h55, 16'h1234, 16'h0, 16'h55);
		calc(sect14_mode, 16'h255, 16'hfe00, 16'h0, 16'h3e55);
		calc(sect14_mode, 16'h41ff, 16'h0, 16'h7fff, 16'h1fe);
		index_op = 1'h1;
		calc(sect14_mode, 16'h41ff, 16'h0, 16'h7fff, 16'h1ff);
		index_op = 1'h0;
		mem_i.words[16'h15] = 16'hc100;
		mem_i.words[16'h105] = 16'h200;
		lat = 4'h3;
		calc(sect14_mode, 16'hc010, 16'h0, 16'h5, 16'h200);
		lat = 4'h0;
		mem_i.words[16'h15] = 16'h300;
		mem_i.words[16'h40] = 16'h4300;
		calc(sect15_mode, 16'hc010, 16'h0, 16'h5, 16'h300);
		calc(sect15_mode, 16'hc040, 16'h0, 16'h5, 16'h4305);
	endtask : t_sect
	task automatic t_rel();
		calc(rel15_mode, 16'h2ff, 16'h7fff, 16'h0, 16'hff);
		calc(rel16_mode, 16'h42ff, 16'h7fff, 16'h1, 16'h8100);
		calc(rel16_mode, 16'h310, 16'h1000, 16'h0, 16'hf11);
		mem_i.words[16'h2001] = 16'hc123;
		calc(rel16_mode, 16'h8200, 16'h2000, 16'h0, 16'hc123);
		for (int c = 0; c < 4; c++) begin
			calc(rel15_mode, 16'h300 | 16'(c), 16'h0, 16'h0, 16'h0);
			`CHK({extended, two_word, ext_class}, {1'h1, c < 2, 2'(c)})
		end
	endtask : t_rel
	task automatic t_clear_trap();
		panel_clear = 1'h1;
		@(negedge clock);
		panel_clear = 1'h0;
		`CHK(mode, sect14_mode)
		mem_top = 16'h3e54;
		calc(sect14_mode, 16'h255, 16'hfe00, 16'h0, 16'h3e55);
		mem_top = 16'hffff;
	endtask : t_clear_trap
	task automatic tally_and_finish();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'h0;
		`CHK(mode, sect14_mode)
		t_sect();
		t_rel();
		t_clear_trap();
		tally_and_finish();
	end
	// Whole run needs well under a microsecond
	initial begin
		#4000;
		fail_count++;
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
